/* File: verification/dsc_bus_master.sv */
// Purpose: behavioural two-wire bus master for the slave core
// Assumes: clk_in paces the bus; one bit takes 64 clk_in cycles
// Notes:   clock idles high between frames; released data reads high
`timescale 1ns/10ps
module dsc_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  // bus idle at time zero
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end

  // all pin changes land on the falling system edge
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // one clock pulse, about 390 kHz; data moves only while clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_drv_out = b;
    wait_clk(22);
    scl_out = 1'b1;
    wait_clk(10);
    r = sda_in;
    wait_clk(10);
    scl_out = 1'b0;
    wait_clk(22);
  endtask

  // start or repeated start, data released first
  task automatic start();
    sda_drv_out = 1'b1;
    wait_clk(22);
    scl_out = 1'b1;
    wait_clk(15);
    sda_drv_out = 1'b0;
    wait_clk(15);
    scl_out = 1'b0;
    wait_clk(22);
  endtask

  // stop, then bus free time before anything else
  task automatic stop();
    sda_drv_out = 1'b0;
    wait_clk(22);
    scl_out = 1'b1;
    wait_clk(15);
    sda_drv_out = 1'b1;
    wait_clk(35);
  endtask

  // eight data bits then the acknowledge pulse
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // read a byte; master ack low to continue, high to end
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule

/* File: verification/dsc_core_asserts.sv */
// Purpose: port-level checks of the serial slave core
// Assumes: bus pins far slower than clk_in, ce_in held high
// Notes:   bound to every dsc_core instance
`timescale 1ns/10ps
module dsc_core_asserts #(
  parameter int CODE_W = 10
) (
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic              ce_in,
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              addr_sel_in,
  input wire logic              sda_out,
  input wire logic              sda_oe_n_out,
  input wire logic [CODE_W-1:0] channel_a_output_out,
  input wire logic [CODE_W-1:0] channel_b_output_out,
  input wire logic [1:0]        power_down_sel_hi_out,
  input wire logic [1:0]        power_down_sel_lo_out,
  input wire logic [1:0]        pd_float_out,
  input wire logic [1:0]        pd_term_1k_out,
  input wire logic [1:0]        pd_term_100k_out,
  input wire logic              bus_active_out
);
  logic [2*CODE_W+3:0] regs_all;

  default clocking dflt_cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // output codes and power-down selectors the bus can change, watched as one word
  assign regs_all = {channel_a_output_out, channel_b_output_out,
                     power_down_sel_hi_out, power_down_sel_lo_out};

  // bus conditions and the drive hold, as seen on the pins
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_drive_held;
    !scl_in ##1 !sda_oe_n_out [*8];
  endsequence

  // framing, drive, commit timing and power-down decode
  AST_START_WAKES: assert property (s_start |-> ##[1:6] bus_active_out)
    else $error("engine not active after start");
  AST_STOP_IDLES: assert property (s_stop |-> ##[1:6] !bus_active_out)
    else $error("engine still active after stop");
  AST_IDLE_RELEASED: assert property (!bus_active_out |-> sda_oe_n_out)
    else $error("data driven while idle");
  AST_QUIET_HIGH: assert property (scl_in |-> $stable(sda_oe_n_out))
    else $error("data drive changed while clock high");
  AST_ACK_HELD: assert property ($fell(sda_oe_n_out) |-> s_drive_held)
    else $error("data drive too short or begun in clock high");
  AST_PIN_LOW_ONLY: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_COMMIT_AFTER_FALL: assert property (
    $changed(regs_all) |-> !$past(scl_in, 2) && $past(scl_in, 6))
    else $error("register changed away from a clock fall");
  AST_IDLE_HOLDS: assert property (
    !bus_active_out && !$past(bus_active_out) |-> $stable(regs_all))
    else $error("register changed while bus ignored");
  AST_PD_DECODE: assert property (
    pd_float_out == (~power_down_sel_hi_out & power_down_sel_lo_out)
    && pd_term_1k_out == (power_down_sel_hi_out & ~power_down_sel_lo_out)
    && pd_term_100k_out == (power_down_sel_hi_out & power_down_sel_lo_out))
    else $error("power-down decode wrong");
  // reset state must not be masked by the reset itself
  AST_RESET_STATE: assert property (disable iff (1'b0)
    !resetn_in && ce_in |=> channel_a_output_out == '0 && channel_b_output_out == '0
    && power_down_sel_hi_out == 2'h3 && power_down_sel_lo_out == 2'h3 && sda_oe_n_out)
    else $error("reset state wrong");
endmodule

bind dsc_core dsc_core_asserts #(.CODE_W(CODE_W)) chk_u (
  .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .scl_in(scl_in),
  .sda_in(sda_in), .addr_sel_in(addr_sel_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .channel_a_output_out(channel_a_output_out),
  .channel_b_output_out(channel_b_output_out),
  .power_down_sel_hi_out(power_down_sel_hi_out),
  .power_down_sel_lo_out(power_down_sel_lo_out), .pd_float_out(pd_float_out),
  .pd_term_1k_out(pd_term_1k_out), .pd_term_100k_out(pd_term_100k_out),
  .bus_active_out(bus_active_out)
);

/* File: verification/tb_top.sv */
// Purpose: self-checking bench of the dual converter serial slave core
// Assumes: the bus master model paces the serial clock from clk_in
// Notes:   a small reference model tracks input and output registers
`timescale 1ns/10ps
module tb_top;
  logic       clk_in;
  logic       resetn_in;
  logic       addr_sel_in;
  logic       scl;
  logic       sda_m;
  logic       sda_oe_n;
  logic       sda_o;
  logic       bus_act;
  logic       ack;
  logic [7:0] rd;
  logic [9:0] out_a, out_b, in_a_m, in_b_m, out_a_m, out_b_m;
  logic [1:0] pd_hi, pd_lo, pd_fl, pd_1k, pd_100k, hi_m, lo_m;
  wire        sda_w;
  int         errors;
  int         total_checks;
  logic [3:0] cmds [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE};
  logic [9:0] codes [9] = '{10'h155, 10'h2AA, 10'h3FF, 10'h001, 10'h200, 10'h0F0,
                            10'h123, 10'h321, 10'h000};

  // open-drain data wire with pull-up
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  // system clock, 40 ns period
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  dsc_core dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda_w),
    .addr_sel_in(addr_sel_in), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .channel_a_output_out(out_a), .channel_b_output_out(out_b),
    .power_down_sel_hi_out(pd_hi), .power_down_sel_lo_out(pd_lo), .pd_float_out(pd_fl),
    .pd_term_1k_out(pd_1k), .pd_term_100k_out(pd_100k), .bus_active_out(bus_act)
  );
  dsc_bus_master bm_u (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_drv_out(sda_m));

  // compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single exit of the run
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // all visible registers against the reference
  task automatic check_regs();
    check("chan_a", 16'(out_a), 16'(out_a_m));
    check("chan_b", 16'(out_b), 16'(out_b_m));
    check("pd_hi", 16'(pd_hi), 16'(hi_m));
    check("pd_lo", 16'(pd_lo), 16'(lo_m));
    check("pd_float", 16'(pd_fl), {14'h0, ~hi_m & lo_m});
    check("pd_1k", 16'(pd_1k), {14'h0, hi_m & ~lo_m});
    check("pd_100k", 16'(pd_100k), {14'h0, hi_m & lo_m});
  endtask

  // two-cycle reset, reference back to power-up state
  task automatic do_reset();
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    out_a_m = '0;
    out_b_m = '0;
    in_a_m = '0;
    in_b_m = '0;
    hi_m = 2'h3;
    lo_m = 2'h3;
    repeat (3) @(negedge clk_in);
    check_regs();
    check("pd_100k", 16'(pd_100k), 16'h3);
  endtask

  task automatic open_frame(input logic [7:0] a, input logic exp);
    bm_u.start();
    bm_u.wr_byte(a, ack);
    check("ack_addr", 16'(ack), 16'(exp));
  endtask

  // one command; reference updated as the command table says
  task automatic wr_cmd(input logic [3:0] c, input logic [9:0] d);
    bm_u.wr_byte({c, d[9:6]}, ack);
    check("ack_cmd", 16'(ack), 16'h1);
    // the update command carries no data byte
    if (c != 4'hE) begin
      bm_u.wr_byte({d[5:0], 2'h0}, ack);
      check("ack_data", 16'(ack), 16'h1);
    end
    if (c == 4'h8 || c == 4'h9) begin
      out_a_m = in_a_m;
      out_b_m = in_b_m;
    end
    if (c inside {4'h0, 4'h4, 4'h8, 4'hC, 4'hD}) in_a_m = d;
    if (c inside {4'h1, 4'h5, 4'h9, 4'hC, 4'hD}) in_b_m = d;
    if (c inside {4'h0, 4'h1, 4'hC, 4'hE}) begin
      out_a_m = in_a_m;
      out_b_m = in_b_m;
    end
    check_regs();
  endtask

  // extended command: mode m on the channels set in ch (bit0 a)
  task automatic wr_ext(input logic [1:0] m, input logic [1:0] ch);
    bm_u.wr_byte(8'hF0, ack);
    bm_u.wr_byte({m, 2'h0, ch, 2'h0}, ack);
    check("ack_ext", 16'(ack), 16'h1);
    hi_m = (hi_m & ~ch) | (ch & {2{m[1]}});
    lo_m = (lo_m & ~ch) | (ch & {2{m[0]}});
    check_regs();
  endtask

  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    addr_sel_in = 1'b0;
    do_reset();
    // wrong address: no ack, later bytes ignored
    open_frame(8'h72, 1'b0);
    bm_u.wr_byte(8'h05, ack);
    check("ack_ignored", 16'(ack), 16'h0);
    bm_u.wr_byte(8'h54, ack);
    bm_u.stop();
    check_regs();
    // every command but the extended one back to back, still in power-down
    open_frame(8'h70, 1'b1);
    for (int i = 0; i < 9; i++) wr_cmd(cmds[i], codes[i]);
    // repeated start, each mode on channel a, then wake both
    open_frame(8'h70, 1'b1);
    for (int m = 1; m < 5; m++) wr_ext(2'(m), 2'h1);
    wr_ext(2'h0, 2'h3);
    bm_u.stop();
    // write cut short inside the data byte
    open_frame(8'h70, 1'b1);
    bm_u.wr_byte(8'h0F, ack);
    bm_u.bit_x(1'b1, ack);
    bm_u.bit_x(1'b0, ack);
    bm_u.stop();
    check_regs();
    check("bus_idle", 16'(bus_act), 16'h0);
    // write channel b, then read it back over a repeated start
    open_frame(8'h70, 1'b1);
    wr_cmd(4'h1, 10'h2C7);
    open_frame(8'h71, 1'b1);
    bm_u.rd_byte(1'b1, rd);
    check("rd_hi", 16'(rd), 16'({hi_m[1], lo_m[1], 2'h0, out_b_m[9:6]}));
    bm_u.rd_byte(1'b0, rd);
    check("rd_lo", 16'(rd), 16'({out_b_m[5:0], 2'h0}));
    bm_u.stop();
    // select pin high moves the address
    @(negedge clk_in);
    addr_sel_in = 1'b1;
    open_frame(8'h70, 1'b0);
    bm_u.stop();
    open_frame(8'h72, 1'b1);
    wr_cmd(4'hC, 10'h0AB);
    bm_u.stop();
    // reset in mid-run
    do_reset();
    complete_run();
  end

  // watchdog, about three times the expected run
  initial begin
    repeat (90000) @(posedge clk_in);
    errors++;
    $display("Error watchdog expected done seen timeout");
    complete_run();
  end
endmodule

/* File: verilog/dsc_core.sv */
// Purpose: two-wire slave interface and register core of a dual converter
// Assumes: clk_in far faster than the serial clock; pins are asynchronous
// Notes:   the converter and output stages sit outside this module
`timescale 1ns/10ps
`include "dsc_defines.svh"
module dsc_core #(
  parameter int                   CODE_W  = `DSC_CODE_W,
  parameter logic [5:0]           ADDR_HI = `DSC_ADDR_HI_RESET
) (
  input  wire logic               clk_in,
  input  wire logic               resetn_in,
  input  wire logic               ce_in,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  input  wire logic               addr_sel_in,
  output logic                    sda_out,
  output logic                    sda_oe_n_out,
  output logic [CODE_W-1:0]       channel_a_output_out,
  output logic [CODE_W-1:0]       channel_b_output_out,
  output logic [1:0]              power_down_sel_hi_out,
  output logic [1:0]              power_down_sel_lo_out,
  output logic [1:0]              pd_float_out,
  output logic [1:0]              pd_term_1k_out,
  output logic [1:0]              pd_term_100k_out,
  output logic                    bus_active_out
);
  import dsc_pkg::*;

  // refuse sizes and clock rates the engine cannot serve
  if (CODE_W != `DSC_CODE_W) begin : g_bad_width
    $error("code width must equal the 10-bit word packing");
  end
  if (`DSC_SYNC_LAT_CYC >= `DSC_SCL_HIGH_MIN_CYC) begin : g_bad_rate
    $error("clk_in too slow to oversample a 400 kHz serial clock");
  end

  logic              scl_s;
  logic              sda_s;
  logic              sel_s;
  logic              bit_s;
  logic              link_bit;
  logic              scl_q;
  logic              sda_q;
  logic              rose_q;
  dsc_state_t        st_q;
  logic [3:0]        cnt_q;
  logic [7:0]        sh_q;
  logic [7:0]        cmd_q;
  logic [7:0]        tx_q;
  logic              rd_q;
  logic              ack_addr_q;
  logic              tx_hi_q;
  logic              rd_sel_q;
  dsc_wbyte_t        wb_q;
  logic [CODE_W-1:0] in_a_q;
  logic [CODE_W-1:0] in_b_q;
  logic [1:0]        pd_a_q;
  logic [1:0]        pd_b_q;
  logic              start_ev;
  logic              stop_ev;
  logic              rise_ev;
  logic              fall_ev;
  logic              fall_ok;
  logic [7:0]        byte_in;
  logic              commit;
  logic [3:0]        c_nib;
  logic [CODE_W-1:0] d_word;
  logic [7:0]        tx_first;
  logic [7:0]        tx_second;
  logic [CODE_W-1:0] rd_code;
  logic [1:0]        rd_pd;

  // bit capture runs on the bus clock itself
  dsc_link_sampler u_link (
    .scl_clk_in (scl_in),
    .sda_in     (sda_in),
    .bit_out    (link_bit)
  );

  // pins and the captured bit cross into clk_in
  dsc_sync #(.WIDTH(4)) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .async_in  ({scl_in, sda_in, addr_sel_in, link_bit}),
    .sync_out  ({scl_s, sda_s, sel_s, bit_s})
  );

  // previous line levels for edge and condition detection
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_in) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // data moving while clock stays high is a condition, never data
  assign start_ev = scl_q && scl_s && sda_q && !sda_s;
  assign stop_ev  = scl_q && scl_s && !sda_q && sda_s;
  assign rise_ev  = !scl_q && scl_s;
  assign fall_ev  = scl_q && !scl_s;
  // a fall only counts once a rise followed the START
  assign fall_ok  = fall_ev && rose_q;
  assign byte_in  = {sh_q[6:0], bit_s};

  // remembers whether a clock pulse has passed since the last START
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rose_q <= 1'b0;
    end else if (ce_in) begin
      if (start_ev) begin
        rose_q <= 1'b0;
      end else if (rise_ev) begin
        rose_q <= 1'b1;
      end
    end
  end

  // write decode: which byte closes which command
  assign c_nib  = (wb_q == DSC_WB_DATA) ? cmd_q[7:4] : sh_q[7:4];
  assign d_word = {cmd_q[3:0], sh_q[7:2]};
  // updates land on the fall that ends the acknowledge slot
  assign commit = fall_ok && (st_q == DSC_ST_ACK) && !ack_addr_q;

  // protocol engine; idle state waits for the next START
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st_q       <= DSC_ST_IDLE;
      cnt_q      <= 4'h0;
      sh_q       <= 8'h00;
      rd_q       <= 1'b0;
      ack_addr_q <= 1'b0;
      wb_q       <= DSC_WB_CMD;
      cmd_q      <= 8'h00;
    end else if (ce_in) begin
      if (start_ev) begin
        // repeated START restarts cleanly, dropping any half write
        st_q  <= DSC_ST_ADDR;
        cnt_q <= 4'h0;
        wb_q  <= DSC_WB_CMD;
      end else if (stop_ev && rose_q) begin
        st_q <= DSC_ST_IDLE;
      end else if (fall_ok) begin
        case (st_q)
          DSC_ST_ADDR, DSC_ST_WRITE: begin
            sh_q  <= byte_in;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `DSC_LAST_BIT) begin
              cnt_q <= 4'h0;
              if (st_q == DSC_ST_WRITE) begin
                st_q       <= DSC_ST_ACK;
                ack_addr_q <= 1'b0;
              end else if (byte_in[7:1] == {ADDR_HI, sel_s}) begin
                st_q       <= DSC_ST_ACK;
                ack_addr_q <= 1'b1;
                rd_q       <= byte_in[0];
              end else begin
                st_q <= DSC_ST_IDLE;
              end
            end
          end
          DSC_ST_ACK: begin
            if (ack_addr_q && rd_q) begin
              st_q <= DSC_ST_READ;
            end else begin
              st_q <= DSC_ST_WRITE;
            end
            if (!ack_addr_q) begin
              case (wb_q)
                DSC_WB_CMD: begin
                  cmd_q <= sh_q;
                  if (sh_q[7:4] == DSC_CMD_UPDATE) begin
                    wb_q <= DSC_WB_CMD;
                  end else if (sh_q == {DSC_CMD_EXTENDED, `DSC_EXT_DATA_NIB}) begin
                    wb_q <= DSC_WB_EXT;
                  end else begin
                    wb_q <= DSC_WB_DATA;
                  end
                end
                default: wb_q <= DSC_WB_CMD;
              endcase
            end
          end
          DSC_ST_READ: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `DSC_LAST_BIT) begin
              cnt_q <= 4'h0;
              st_q  <= DSC_ST_RACK;
            end
          end
          DSC_ST_RACK: begin
            // low means the master wants another byte
            st_q <= bit_s ? DSC_ST_IDLE : DSC_ST_READ;
          end
          default: st_q <= DSC_ST_IDLE;
        endcase
      end
    end
  end

  // read-back words: selector bits, then the code high and low parts
  assign rd_code   = rd_sel_q ? channel_b_output_out : channel_a_output_out;
  assign rd_pd     = rd_sel_q ? pd_b_q : pd_a_q;
  assign tx_first  = {rd_pd, 2'h0, rd_code[9:6]};
  assign tx_second = {rd_code[5:0], 2'h0};

  // transmit shifter and which half goes next
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_q    <= 8'h00;
      tx_hi_q <= 1'b1;
    end else if (ce_in && fall_ok) begin
      if (st_q == DSC_ST_ACK && ack_addr_q && rd_q) begin
        tx_q    <= tx_first;
        tx_hi_q <= 1'b0;
      end else if (st_q == DSC_ST_RACK && !bit_s) begin
        tx_q    <= tx_hi_q ? tx_first : tx_second;
        tx_hi_q <= !tx_hi_q;
      end else if (st_q == DSC_ST_READ) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // open-drain data: enable low pulls the line, clock never driven
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sda_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      if (start_ev || (stop_ev && rose_q)) begin
        sda_oe_n_out <= 1'b1;
      end else if (fall_ok) begin
        case (st_q)
          DSC_ST_ADDR: begin
            sda_oe_n_out <= !((cnt_q == `DSC_LAST_BIT)
                              && (byte_in[7:1] == {ADDR_HI, sel_s}));
          end
          DSC_ST_WRITE: sda_oe_n_out <= !(cnt_q == `DSC_LAST_BIT);
          DSC_ST_ACK: begin
            sda_oe_n_out <= !(ack_addr_q && rd_q && !tx_first[7]);
          end
          DSC_ST_READ: begin
            // ninth slot belongs to the master
            sda_oe_n_out <= (cnt_q == `DSC_LAST_BIT) ? 1'b1 : tx_q[6];
          end
          DSC_ST_RACK: begin
            sda_oe_n_out <= bit_s | (tx_hi_q ? tx_first[7] : tx_second[7]);
          end
          default: sda_oe_n_out <= 1'b1;
        endcase
      end
    end
  end

  // line level when enabled is always low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sda_out <= 1'b0;
    end else if (ce_in) begin
      sda_out <= 1'b0;
    end
  end

  // input and output registers, touched only by a finished write
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      in_a_q               <= '0;
      in_b_q               <= '0;
      channel_a_output_out <= '0;
      channel_b_output_out <= '0;
      rd_sel_q             <= 1'b0;
    end else if (ce_in && commit && wb_q != DSC_WB_EXT) begin
      // held indefinitely otherwise, nothing decays
      if (wb_q == DSC_WB_DATA) begin
        rd_sel_q <= c_nib[0];
      end
      case (c_nib)
        DSC_CMD_LOAD_A_ALL: if (wb_q == DSC_WB_DATA) begin
          in_a_q               <= d_word;
          channel_a_output_out <= d_word;
          channel_b_output_out <= in_b_q;
        end
        DSC_CMD_LOAD_B_ALL: if (wb_q == DSC_WB_DATA) begin
          in_b_q               <= d_word;
          channel_b_output_out <= d_word;
          channel_a_output_out <= in_a_q;
        end
        DSC_CMD_IN_A: if (wb_q == DSC_WB_DATA) in_a_q <= d_word;
        DSC_CMD_IN_B: if (wb_q == DSC_WB_DATA) in_b_q <= d_word;
        DSC_CMD_XFER_IN_A, DSC_CMD_XFER_IN_B: if (wb_q == DSC_WB_DATA) begin
          channel_a_output_out <= in_a_q;
          channel_b_output_out <= in_b_q;
          if (c_nib[0]) in_b_q <= d_word;
          else in_a_q <= d_word;
        end
        DSC_CMD_BOTH_ALL: if (wb_q == DSC_WB_DATA) begin
          in_a_q               <= d_word;
          in_b_q               <= d_word;
          channel_a_output_out <= d_word;
          channel_b_output_out <= d_word;
        end
        DSC_CMD_BOTH_IN: if (wb_q == DSC_WB_DATA) begin
          in_a_q <= d_word;
          in_b_q <= d_word;
        end
        DSC_CMD_UPDATE: if (wb_q == DSC_WB_CMD) begin
          // single-byte command, no data byte follows
          channel_a_output_out <= in_a_q;
          channel_b_output_out <= in_b_q;
        end
        default: ;
      endcase
    end
  end

  // power-down selectors; codes are untouched so wake-up restores them
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pd_a_q <= `DSC_PD_RESET;
      pd_b_q <= `DSC_PD_RESET;
    end else if (ce_in && commit && wb_q == DSC_WB_EXT) begin
      if (sh_q[`DSC_EXT_A_BIT]) begin
        pd_a_q <= {sh_q[`DSC_EXT_PD_HI_BIT], sh_q[`DSC_EXT_PD_LO_BIT]};
      end
      if (sh_q[`DSC_EXT_B_BIT]) begin
        pd_b_q <= {sh_q[`DSC_EXT_PD_HI_BIT], sh_q[`DSC_EXT_PD_LO_BIT]};
      end
    end
  end

  // decoded termination controls, one bit per channel (0 = a, 1 = b)
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      power_down_sel_hi_out <= 2'h3;
      power_down_sel_lo_out <= 2'h3;
      pd_float_out          <= 2'h0;
      pd_term_1k_out        <= 2'h0;
      pd_term_100k_out      <= 2'h3;
      bus_active_out        <= 1'b0;
    end else if (ce_in) begin
      power_down_sel_hi_out <= {pd_b_q[1], pd_a_q[1]};
      power_down_sel_lo_out <= {pd_b_q[0], pd_a_q[0]};
      pd_float_out          <= {pd_b_q == `DSC_PD_FLOAT, pd_a_q == `DSC_PD_FLOAT};
      pd_term_1k_out        <= {pd_b_q == `DSC_PD_1K, pd_a_q == `DSC_PD_1K};
      pd_term_100k_out      <= {pd_b_q == `DSC_PD_100K, pd_a_q == `DSC_PD_100K};
      bus_active_out        <= (st_q != DSC_ST_IDLE);
    end
  end

endmodule

/* File: verilog/dsc_defines.svh */
// Purpose: shared constants of the dual converter serial slave core
// Assumes: included by bare name, definitions only
// Notes:   times are in ns, cycle counts derive from the clk_in period
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// converter code and word layout
`define DSC_CODE_W        10
`define DSC_BYTE_W        8
`define DSC_LAST_BIT      4'h7
// slave address, upper six bits preset, lowest from the select pin
`define DSC_ADDR_HI_RESET 6'h1C
// power-down selector encodings {hi, lo}
`define DSC_PD_ON         2'h0
`define DSC_PD_FLOAT      2'h1
`define DSC_PD_1K         2'h2
`define DSC_PD_100K       2'h3
`define DSC_PD_RESET      2'h3
// extended power-down byte fields
`define DSC_EXT_PD_HI_BIT 7
`define DSC_EXT_PD_LO_BIT 6
`define DSC_EXT_B_BIT     3
`define DSC_EXT_A_BIT     2
// extended command data nibble must be zero
`define DSC_EXT_DATA_NIB  4'h0
// timing
`define DSC_CLK_PERIOD_NS   40
`define DSC_SCL_MAX_KHZ     400
`define DSC_SCL_HIGH_MIN_NS 600
`define DSC_SCL_HIGH_MIN_CYC \
  ((`DSC_SCL_HIGH_MIN_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
// two synchroniser stages plus one edge register
`define DSC_SYNC_LAT_CYC    3

`endif

/* File: verilog/dsc_link_sampler.sv */
// Purpose: captures the data line on each rising serial clock edge
// Assumes: scl_clk_in is the bus clock and may stop between frames
// Notes:   the held bit is read by the core only after the clock falls
`timescale 1ns/10ps
module dsc_link_sampler (
  input  wire logic scl_clk_in,
  input  wire logic sda_in,
  output logic      bit_out
);

  // bit stays stable through the whole low period that follows
  always_ff @(posedge scl_clk_in) begin
    bit_out <= sda_in;
  end

endmodule

/* File: verilog/dsc_pkg.sv */
// Purpose: types of the dual converter serial slave core
// Assumes: nothing beyond the defines header
// Notes:   command codes are the upper nibble of the command byte
package dsc_pkg;

  // protocol engine states
  typedef enum logic [2:0] {
    DSC_ST_IDLE,
    DSC_ST_ADDR,
    DSC_ST_WRITE,
    DSC_ST_ACK,
    DSC_ST_READ,
    DSC_ST_RACK
  } dsc_state_t;

  // command nibble encodings
  typedef enum logic [3:0] {
    DSC_CMD_LOAD_A_ALL  = 4'h0,
    DSC_CMD_LOAD_B_ALL  = 4'h1,
    DSC_CMD_IN_A        = 4'h4,
    DSC_CMD_IN_B        = 4'h5,
    DSC_CMD_XFER_IN_A   = 4'h8,
    DSC_CMD_XFER_IN_B   = 4'h9,
    DSC_CMD_BOTH_ALL    = 4'hC,
    DSC_CMD_BOTH_IN     = 4'hD,
    DSC_CMD_UPDATE      = 4'hE,
    DSC_CMD_EXTENDED    = 4'hF
  } dsc_cmd_t;

  // which byte of a write sequence comes next
  typedef enum logic [1:0] {
    DSC_WB_CMD,
    DSC_WB_DATA,
    DSC_WB_EXT
  } dsc_wbyte_t;

endpackage

/* File: verilog/dsc_sync.sv */
// Purpose: two-stage level synchroniser, one per bit
// Assumes: inputs are levels that stay put for several destination cycles
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module dsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // idle-high reset matches an idle bus
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else if (ce_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
